// file: verilog/lac_regs.svh
`ifndef LAC_REGS_SVH
`define LAC_REGS_SVH
// Register offsets on the loader port
`define LAC_OFF_CMD 4'h0
`define LAC_OFF_KEY 4'h1
`define LAC_OFF_RESP 4'h2
`define LAC_OFF_STAT 4'h3
`define LAC_OFF_CHAL 4'h4
// Command field positions
`define LAC_CMD_OP_LSB 0
`define LAC_CMD_ARG_LSB 4
// Command codes
`define LAC_OP_ADVANCE 4'h1
`define LAC_OP_ERASE 4'h2
`define LAC_OP_ERASE_DIS 4'h3
`define LAC_OP_INJECT 4'h4
`define LAC_OP_REGRESS 4'h5
`define LAC_OP_ABORT 4'h6
// Key slots
`define LAC_KSEL_SEC 2'h0
`define LAC_KSEL_NS 2'h1
`define LAC_KSEL_RET 2'h2
// Result codes in status
`define LAC_RES_OK 2'h0
`define LAC_RES_BUSY 2'h1
`define LAC_RES_REJECT 2'h2
`define LAC_RES_AUTHFAIL 2'h3
// Reset values
`define LAC_CHAL_SEED 32'h5a3c96e1
`define LAC_RDATA_RST 32'h0000_0000
`endif

// file: verilog/lac_pkg.sv
package lac_pkg;
  // Lifecycle states, in development-to-production order
  typedef enum logic [2:0] {
    chip_manufacture_state,
    secure_development_state,
    nonsecure_development_state,
    deployed_state,
    debug_locked_state,
    boot_locked_state,
    return_request_state,
    return_acknowledged_state
  } lac_lc_e;
  typedef enum logic [1:0] {
    no_debug_level,
    nonsecure_debug_level,
    full_debug_level
  } lac_dbg_e;
  typedef enum logic [1:0] {
    flash_none,
    flash_nonsecure,
    flash_all
  } lac_flash_e;
  typedef enum logic [1:0] {
    ctl_idle,
    ctl_auth,
    ctl_erase
  } lac_ctl_e;
  typedef logic [31:0] lac_word_t;
  // Controller state
  typedef struct packed {
    logic loaded;
    lac_lc_e lc;
    lac_lc_e target;
    lac_ctl_e fsm;
    logic [2:0][31:0] keys;
    logic [2:0] key_valid;
    logic erase_dis;
    logic [31:0] key_buf;
    logic [1:0] result;
    logic nv_wr;
    logic erase_req;
    logic [31:0] rdata;
    logic boot_s1;
    logic boot_s2;
    logic dbg_s1;
    logic dbg_s2;
  } lac_top_s;
  // Authentication engine state
  typedef struct packed {
    logic [31:0] lfsr;
    logic [31:0] chal;
    logic [31:0] key;
    logic busy;
    logic pass;
    logic fail;
  } lac_auth_s;
endpackage

// file: verilog/lac_auth_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lac_auth_if;
  logic start;
  logic [31:0] key;
  logic resp_valid;
  logic [31:0] resp;
  logic abort;
  logic [31:0] challenge;
  logic busy;
  logic pass;
  logic fail;
  modport ctl (output start, key, resp_valid, resp, abort,
    input challenge, busy, pass, fail);
  modport eng (input start, key, resp_valid, resp, abort,
    output challenge, busy, pass, fail);
endinterface
`default_nettype wire

// file: verilog/lac_auth.sv
`timescale 1ns/10ps
`default_nettype none
`include "lac_regs.svh"
module lac_auth (
  input wire logic clk_sys,
  input wire logic rst_n,
  lac_auth_if.eng au
);
  import lac_pkg::*;

  lac_auth_s a_reg;
  lac_auth_s a_next;

  // Expected answer for a challenge under a key
  function automatic logic [31:0] lac_expect(input logic [31:0] c, input logic [31:0] k);
    lac_expect = {c[15:0], c[31:16]} ^ k ^ {k[7:0], k[31:8]};
  endfunction

  // Free-running generator, fresh challenge per exchange
  always_comb
  begin
    a_next = a_reg;
    a_next.pass = 1'b0;
    a_next.fail = 1'b0;
    a_next.lfsr = {a_reg.lfsr[30:0],
      a_reg.lfsr[31] ^ a_reg.lfsr[21] ^ a_reg.lfsr[1] ^ a_reg.lfsr[0]};
    if (au.start)
    begin
      a_next.chal = a_reg.lfsr;
      a_next.key = au.key;
      a_next.busy = 1'b1;
    end
    else if (a_reg.busy && au.abort)
    begin
      a_next.busy = 1'b0;
      a_next.fail = 1'b1;
    end
    else if (a_reg.busy && au.resp_valid)
    begin
      a_next.busy = 1'b0;
      a_next.pass = (au.resp == lac_expect(a_reg.chal, a_reg.key));
      a_next.fail = (au.resp != lac_expect(a_reg.chal, a_reg.key));
      a_next.chal = a_reg.lfsr; // Spent challenge never reused
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      a_reg <= '0;
      a_reg.lfsr <= `LAC_CHAL_SEED;
    end
    else
    begin
      a_reg <= a_next;
    end
  end

  assign au.challenge = a_reg.chal;
  assign au.busy = a_reg.busy;
  assign au.pass = a_reg.pass;
  assign au.fail = a_reg.fail;
endmodule
`default_nettype wire

// file: verilog/lac_top.sv
// What this block does
// - Full debug level: debugger admitted with secure and non-secure access.
// - Non-secure debug level: debugger admitted, non-secure access only.
// - No-debug level: every debugger connection refused.
// - Loader commands only honoured in boot mode.
// - Chip manufacture: full debug, loader on, no flash access.
// - Secure development: full debug, loader reaches all flash.
// - Non-secure development: non-secure debug, loader reaches non-secure flash.
// - Deployed: no debug, loader on, no flash access.
// - Debug locked: debug off until a full erase, loader on, no flash access.
// - Boot locked: debug and loader both dead.
// - Return request: no debug, loader on, no flash access.
// - Return acknowledged: full debug, loader on, no flash access.
// - Unauthenticated moves only go forward toward less access.
// - Full erase wipes flash then sets secure development state.
// - Full erase refused while any permanent block protection exists.
// - Full erase disable is one way.
// - Authenticated regression keeps flash untouched.
// - Regression needs the answer to a fresh challenge under a key.
// - Secure key: inject in secure dev, regresses non-secure dev to secure dev.
// - Non-secure key: inject in non-secure dev, regresses deployed to it.
// - Deployed to secure dev takes two authenticated steps.
// - Return key: inject in secure dev, moves secure dev or deployed to return.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "lac_regs.svh"
module lac_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic boot_mode_pin,
  input wire logic dbg_connect_pin,
  output logic dbg_connect_ack,
  output logic dbg_secure_en,
  output logic dbg_nonsecure_en,
  output logic loader_en,
  output lac_pkg::lac_flash_e flash_access,
  input wire logic flash_perm_prot,
  output logic flash_erase_req,
  input wire logic flash_erase_done,
  input wire lac_pkg::lac_lc_e nv_lc,
  input wire logic [2:0] nv_key_valid,
  input wire logic [2:0][31:0] nv_keys,
  input wire logic nv_erase_dis,
  output logic nv_wr,
  output lac_pkg::lac_lc_e nv_lc_next,
  output logic [2:0] nv_key_valid_next,
  output logic [2:0][31:0] nv_keys_next,
  output logic nv_erase_dis_next
);
  import lac_pkg::*;

  lac_top_s s_reg;
  lac_top_s s_next;
  lac_auth_if au ();
  lac_dbg_e dbg_level;
  lac_flash_e flash_level;
  logic serial_ok;
  logic cmd_wr;
  logic [3:0] op;
  logic [2:0] arg;
  logic fwd_ok;
  logic rg_ok;
  lac_lc_e rg_target;
  logic [1:0] rg_key;

  // Debug level from lifecycle state
  always_comb
  begin
    dbg_level = no_debug_level;
    if (s_reg.loaded)
    begin
      case (s_reg.lc)
        chip_manufacture_state: dbg_level = full_debug_level;
        secure_development_state: dbg_level = full_debug_level;
        nonsecure_development_state: dbg_level = nonsecure_debug_level;
        return_acknowledged_state: dbg_level = full_debug_level;
        default: dbg_level = no_debug_level;
      endcase
    end
  end

  // Loader flash rights from lifecycle state
  always_comb
  begin
    flash_level = flash_none;
    if (s_reg.loaded)
    begin
      case (s_reg.lc)
        secure_development_state: flash_level = flash_all;
        nonsecure_development_state: flash_level = flash_nonsecure;
        default: flash_level = flash_none;
      endcase
    end
  end

  // Loader alive only in boot mode and not boot locked
  assign serial_ok = s_reg.loaded && s_reg.boot_s2
    && (s_reg.lc != boot_locked_state);
  assign cmd_wr = reg_wr && (reg_addr == `LAC_OFF_CMD) && serial_ok;
  assign op = reg_wdata[`LAC_CMD_OP_LSB +: 4];
  assign arg = reg_wdata[`LAC_CMD_ARG_LSB +: 3];

  // Forward moves: strictly later in the production chain
  always_comb
  begin
    fwd_ok = (lac_lc_e'(arg) > s_reg.lc)
      && (lac_lc_e'(arg) != chip_manufacture_state)
      && (lac_lc_e'(arg) <= boot_locked_state)
      && (s_reg.lc <= debug_locked_state);
  end

  // Regression targets and their keys
  always_comb
  begin
    rg_ok = 1'b0;
    rg_target = s_reg.lc;
    rg_key = `LAC_KSEL_SEC;
    if ((lac_lc_e'(arg) == secure_development_state)
      && (s_reg.lc == nonsecure_development_state))
    begin
      rg_ok = s_reg.key_valid[`LAC_KSEL_SEC];
      rg_target = secure_development_state;
      rg_key = `LAC_KSEL_SEC;
    end
    else if ((lac_lc_e'(arg) == nonsecure_development_state)
      && (s_reg.lc == deployed_state))
    begin
      rg_ok = s_reg.key_valid[`LAC_KSEL_NS];
      rg_target = nonsecure_development_state;
      rg_key = `LAC_KSEL_NS;
    end
    else if ((lac_lc_e'(arg) == return_request_state)
      && ((s_reg.lc == secure_development_state) || (s_reg.lc == deployed_state)))
    begin
      rg_ok = s_reg.key_valid[`LAC_KSEL_RET];
      rg_target = return_request_state;
      rg_key = `LAC_KSEL_RET;
    end
    // Deployed straight to secure dev falls through as refused
  end

  // Requests to the authentication engine
  assign au.start = cmd_wr && (op == `LAC_OP_REGRESS) && rg_ok && (s_reg.fsm == ctl_idle);
  assign au.key = s_reg.keys[rg_key];
  assign au.resp_valid = reg_wr && (reg_addr == `LAC_OFF_RESP) && serial_ok
    && (s_reg.fsm == ctl_auth);
  assign au.resp = reg_wdata;
  assign au.abort = (cmd_wr && (op == `LAC_OP_ABORT) && (s_reg.fsm == ctl_auth))
    || (s_reg.fsm == ctl_auth && !serial_ok);

  // Next-state logic of the controller
  always_comb
  begin
    s_next = s_reg;
    s_next.nv_wr = 1'b0;
    s_next.erase_req = 1'b0;
    s_next.rdata = `LAC_RDATA_RST;
    s_next.boot_s1 = boot_mode_pin;
    s_next.boot_s2 = s_reg.boot_s1;
    s_next.dbg_s1 = dbg_connect_pin;
    s_next.dbg_s2 = s_reg.dbg_s1;
    if (reg_wr && (reg_addr == `LAC_OFF_KEY) && serial_ok)
    begin
      s_next.key_buf = reg_wdata;
    end
    if (!s_reg.loaded)
    begin
      // Restore persistent state after every reset
      s_next.loaded = 1'b1;
      s_next.lc = nv_lc;
      s_next.keys = nv_keys;
      s_next.key_valid = nv_key_valid;
      s_next.erase_dis = nv_erase_dis;
    end
    else
    begin
      case (s_reg.fsm)
        ctl_idle:
        begin
          if (cmd_wr)
          begin
            s_next.result = `LAC_RES_REJECT;
            if (op == `LAC_OP_ADVANCE)
            begin
              if (fwd_ok)
              begin
                s_next.lc = lac_lc_e'(arg);
                s_next.nv_wr = 1'b1;
                s_next.result = `LAC_RES_OK;
              end
            end
            else if (op == `LAC_OP_ERASE)
            begin
              if (!flash_perm_prot && !s_reg.erase_dis)
              begin
                s_next.fsm = ctl_erase;
                s_next.erase_req = 1'b1;
                s_next.result = `LAC_RES_BUSY;
              end
            end
            else if (op == `LAC_OP_ERASE_DIS)
            begin
              s_next.erase_dis = 1'b1;
              s_next.nv_wr = 1'b1;
              s_next.result = `LAC_RES_OK;
            end
            else if (op == `LAC_OP_INJECT)
            begin
              // Slot codes above the return key name no key
              if (arg[2])
              begin
                s_next.result = `LAC_RES_REJECT;
              end
              else if (((arg[1:0] == `LAC_KSEL_SEC) || (arg[1:0] == `LAC_KSEL_RET))
                && (s_reg.lc == secure_development_state))
              begin
                s_next.keys[arg[1:0]] = s_reg.key_buf;
                s_next.key_valid[arg[1:0]] = 1'b1;
                s_next.nv_wr = 1'b1;
                s_next.result = `LAC_RES_OK;
              end
              else if ((arg[1:0] == `LAC_KSEL_NS)
                && (s_reg.lc == nonsecure_development_state))
              begin
                s_next.keys[`LAC_KSEL_NS] = s_reg.key_buf;
                s_next.key_valid[`LAC_KSEL_NS] = 1'b1;
                s_next.nv_wr = 1'b1;
                s_next.result = `LAC_RES_OK;
              end
            end
            else if (op == `LAC_OP_REGRESS)
            begin
              if (rg_ok)
              begin
                s_next.target = rg_target;
                s_next.fsm = ctl_auth;
                s_next.result = `LAC_RES_BUSY;
              end
            end
          end
        end
        ctl_auth:
        begin
          if (au.pass)
          begin
            s_next.lc = s_reg.target;
            s_next.nv_wr = 1'b1;
            s_next.result = `LAC_RES_OK;
            s_next.fsm = ctl_idle;
          end
          else if (au.fail)
          begin
            s_next.result = `LAC_RES_AUTHFAIL;
            s_next.fsm = ctl_idle;
          end
          // Stray commands only report busy
          else if (cmd_wr && (op != `LAC_OP_ABORT))
          begin
            s_next.result = `LAC_RES_BUSY;
          end
        end
        ctl_erase:
        begin
          // No time limit, waits on the flash
          if (flash_erase_done)
          begin
            s_next.lc = secure_development_state;
            s_next.nv_wr = 1'b1;
            s_next.result = `LAC_RES_OK;
            s_next.fsm = ctl_idle;
          end
        end
        default:
        begin
          s_next.fsm = ctl_idle;
        end
      endcase
    end
    // Read data for the cycle after the strobe
    if (reg_rd)
    begin
      if (reg_addr == `LAC_OFF_STAT)
      begin
        s_next.rdata = {18'h0, s_reg.boot_s2, dbg_level, s_reg.key_valid,
          s_reg.erase_dis, (s_reg.fsm != ctl_idle), s_reg.result,
          s_reg.loaded, s_reg.lc};
      end
      else if ((reg_addr == `LAC_OFF_CHAL) && serial_ok)
      begin
        s_next.rdata = au.challenge;
      end
      else
      begin
        s_next.rdata = `LAC_RDATA_RST;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Challenge-response engine
  lac_auth u_auth (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .au(au)
  );

  // Debug port gating
  assign dbg_connect_ack = s_reg.dbg_s2 && (dbg_level != no_debug_level);
  assign dbg_secure_en = dbg_connect_ack && (dbg_level == full_debug_level);
  assign dbg_nonsecure_en = dbg_connect_ack;

  // Loader gating and persistent-store image
  assign loader_en = serial_ok;
  assign flash_access = serial_ok ? flash_level : flash_none;
  assign flash_erase_req = s_reg.erase_req;
  assign reg_rdata = s_reg.rdata;
  assign nv_wr = s_reg.nv_wr;
  assign nv_lc_next = s_reg.lc;
  assign nv_key_valid_next = s_reg.key_valid;
  assign nv_keys_next = s_reg.keys;
  assign nv_erase_dis_next = s_reg.erase_dis;
endmodule
`default_nettype wire

// file: tb/lac_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "lac_regs.svh"
module lac_top_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic boot_mode_pin,
  input wire logic dbg_connect_pin,
  input wire logic dbg_connect_ack,
  input wire logic dbg_secure_en,
  input wire logic dbg_nonsecure_en,
  input wire logic loader_en,
  input wire lac_pkg::lac_flash_e flash_access,
  input wire logic flash_perm_prot,
  input wire logic flash_erase_req,
  input wire logic flash_erase_done,
  input wire lac_pkg::lac_lc_e nv_lc,
  input wire logic nv_erase_dis,
  input wire logic nv_wr,
  input wire lac_pkg::lac_lc_e nv_lc_next,
  input wire logic nv_erase_dis_next
);
  import lac_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic ld;
  logic dis_q;
  logic ep;
  lac_lc_e lc_q;
  wire logic cmd_wr = reg_wr && reg_addr == `LAC_OFF_CMD;
  // Shadow of the stored image and of a pending erase
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ld <= 1'b0;
      ep <= 1'b0;
    end
    else
    begin
      ld <= 1'b1;
      if (!ld)
      begin
        lc_q <= nv_lc;
        dis_q <= nv_erase_dis;
      end
      else if (nv_wr)
      begin
        lc_q <= nv_lc_next;
        dis_q <= dis_q | nv_erase_dis_next;
      end
      if (flash_erase_req)
        ep <= 1'b1;
      else if (flash_erase_done)
        ep <= 1'b0;
    end
  end
  chk_full_has_ns: assert property (dbg_secure_en |-> dbg_nonsecure_en)
    else $error("secure debug without non-secure debug");
  chk_ack_has_level: assert property (dbg_connect_ack |-> nv_lc_next inside
    {chip_manufacture_state, secure_development_state,
    nonsecure_development_state, return_acknowledged_state})
    else $error("debugger admitted at no-debug level");
  chk_ack_needs_pin: assert property (dbg_connect_ack |-> $past(dbg_connect_pin, 2))
    else $error("debugger admitted without request");
  chk_loader_boot: assert property (loader_en |-> $past(boot_mode_pin, 2))
    else $error("loader on outside boot mode");
  chk_loader_lock: assert property (loader_en |-> ld && lc_q != boot_locked_state)
    else $error("loader on in boot locked state");
  chk_flash_all: assert property (flash_access == flash_all
    |-> nv_lc_next == secure_development_state)
    else $error("full flash access outside secure development");
  chk_flash_ns: assert property (flash_access == flash_nonsecure
    |-> nv_lc_next == nonsecure_development_state)
    else $error("non-secure flash access in wrong state");
  chk_erase_gate: assert property (flash_erase_req |-> $past(cmd_wr) &&
    $past(reg_wdata[3:0]) == `LAC_OP_ERASE && !$past(flash_perm_prot)
    && !$past(nv_erase_dis_next))
    else $error("erase started without accepted command");
  chk_erase_end: assert property (ep && flash_erase_done
    |=> nv_wr && nv_lc_next == secure_development_state)
    else $error("erase end did not store secure development state");
  chk_adv_forward: assert property (ld && nv_wr && $past(cmd_wr) &&
    $past(reg_wdata[3:0]) == `LAC_OP_ADVANCE |-> nv_lc_next > lc_q)
    else $error("advance moved backwards");
  chk_dis_sticky: assert property (ld && nv_wr && dis_q |-> nv_erase_dis_next)
    else $error("erase disable cleared");
  cov_erase: cover property (flash_erase_req);
  cov_to_secdev: cover property (nv_wr && nv_lc_next == secure_development_state);
  cov_full_ack: cover property (dbg_connect_ack && dbg_secure_en);
endmodule
`default_nettype wire

// file: tb/lac_nv_model.sv
`timescale 1ns/10ps
`default_nettype none
module lac_nv_model (
  input wire logic clk_sys,
  input wire logic preset,
  input wire lac_pkg::lac_lc_e preset_lc,
  input wire logic [7:0] erase_dly,
  input wire logic nv_wr,
  input wire lac_pkg::lac_lc_e nv_lc_next,
  input wire logic [2:0] nv_key_valid_next,
  input wire logic [2:0][31:0] nv_keys_next,
  input wire logic nv_erase_dis_next,
  output lac_pkg::lac_lc_e nv_lc,
  output logic [2:0] nv_key_valid,
  output logic [2:0][31:0] nv_keys,
  output logic nv_erase_dis,
  input wire logic flash_erase_req,
  output logic flash_erase_done,
  output int erase_cnt
);
  import lac_pkg::*;
  int cnt;
  // Image survives device reset, only preset clears it
  always @(posedge clk_sys)
  begin
    if (preset)
    begin
      nv_lc <= preset_lc;
      nv_key_valid <= 3'h0;
      nv_keys <= '0;
      nv_erase_dis <= 1'b0;
    end
    else if (nv_wr)
    begin
      nv_lc <= nv_lc_next;
      nv_key_valid <= nv_key_valid_next;
      nv_keys <= nv_keys_next;
      nv_erase_dis <= nv_erase_dis_next;
    end
  end
  // Flash erase ends after a chosen delay
  always @(posedge clk_sys)
  begin
    flash_erase_done <= 1'b0;
    if (preset)
    begin
      erase_cnt <= 0;
      cnt <= 0;
    end
    else if (flash_erase_req)
      cnt <= erase_dly + 1;
    else if (cnt == 1)
    begin
      flash_erase_done <= 1'b1;
      erase_cnt <= erase_cnt + 1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// file: tb/tb_lac_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lac_regs.svh"
module tb_lac_top;
  import lac_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, boot_mode_pin, dbg_connect_pin, flash_perm_prot;
  logic dbg_connect_ack, dbg_secure_en, dbg_nonsecure_en, loader_en, flash_erase_req;
  logic flash_erase_done, nv_erase_dis, nv_wr, nv_erase_dis_next, preset;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, st, ch, c2, k;
  logic [2:0] nv_key_valid, nv_key_valid_next;
  logic [2:0][31:0] nv_keys, nv_keys_next;
  logic [7:0] erase_dly;
  lac_flash_e flash_access;
  lac_lc_e nv_lc, nv_lc_next, preset_lc;
  int failures, compares, erase_cnt, n0;
  int lvl[8] = '{2, 2, 1, 0, 0, 0, 0, 2};
  int fla[8] = '{0, 2, 1, 0, 0, 0, 0, 0};
  lac_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_mode_pin(boot_mode_pin), .dbg_connect_pin(dbg_connect_pin),
    .dbg_connect_ack(dbg_connect_ack), .dbg_secure_en(dbg_secure_en),
    .dbg_nonsecure_en(dbg_nonsecure_en), .loader_en(loader_en), .flash_access(flash_access),
    .flash_perm_prot(flash_perm_prot), .flash_erase_req(flash_erase_req),
    .flash_erase_done(flash_erase_done), .nv_lc(nv_lc), .nv_key_valid(nv_key_valid),
    .nv_keys(nv_keys), .nv_erase_dis(nv_erase_dis), .nv_wr(nv_wr), .nv_lc_next(nv_lc_next),
    .nv_key_valid_next(nv_key_valid_next), .nv_keys_next(nv_keys_next),
    .nv_erase_dis_next(nv_erase_dis_next));
  lac_nv_model u_nv (.clk_sys(clk_sys), .preset(preset), .preset_lc(preset_lc),
    .erase_dly(erase_dly), .nv_wr(nv_wr), .nv_lc_next(nv_lc_next),
    .nv_key_valid_next(nv_key_valid_next), .nv_keys_next(nv_keys_next),
    .nv_erase_dis_next(nv_erase_dis_next), .nv_lc(nv_lc), .nv_key_valid(nv_key_valid),
    .nv_keys(nv_keys), .nv_erase_dis(nv_erase_dis), .flash_erase_req(flash_erase_req),
    .flash_erase_done(flash_erase_done), .erase_cnt(erase_cnt));
  // Free running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected lifecycle after a forward move request
  function automatic int adv(input int c, input int t);
    return (t > c && t <= 5 && c <= 4) ? t : c;
  endfunction
  function automatic logic [31:0] answer(input logic [31:0] c, input logic [31:0] q);
    return {c[15:0], c[31:16]} ^ q ^ {q[7:0], q[31:8]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  // Poll status until the controller is idle
  task automatic settle();
    rd(`LAC_OFF_STAT, st);
    for (int i = 0; i < 40 && st[6] !== 1'b0; i++)
      rd(`LAC_OFF_STAT, st);
    if (st[6] !== 1'b0)
    begin
      failures++;
      $display("[ERR] %0t controller stuck busy", $time);
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] arg);
    wr(`LAC_OFF_CMD, {25'h0, arg, op});
    settle();
  endtask
  task automatic expect_st(input int lc, input int res);
    check(st[2:0], lc, "lifecycle");
    check(st[5:4], res, "result");
  endtask
  task automatic reboot(input logic pre, input lac_lc_e s);
    preset <= pre;
    preset_lc <= s;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    preset <= 1'b0;
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  initial
  begin
    {failures, compares} = 0;
    {rst_n, reg_wr, reg_rd, flash_perm_prot} = 4'h0;
    {boot_mode_pin, dbg_connect_pin, preset} = 3'h7;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    preset_lc = chip_manufacture_state;
    seed = 32'd10331;
    erase_dly = 8'h3;
    // Levels and loader rights for every stored state
    for (int s = 0; s < 8; s++)
    begin
      reboot(1'b1, lac_lc_e'(s));
      check(dbg_connect_ack, lvl[s] != 0, "ack");
      check(dbg_secure_en, lvl[s] == 2, "secure dbg");
      check(dbg_nonsecure_en, lvl[s] != 0, "ns dbg");
      check(loader_en, s != 5, "loader");
      check(flash_access, fla[s], "flash");
      rd(`LAC_OFF_STAT, st);
      check(st[12:11], lvl[s], "level");
    end
    // Boot mode and debug request withdrawn
    reboot(1'b1, chip_manufacture_state);
    boot_mode_pin <= 1'b0;
    dbg_connect_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(loader_en, 1'b0, "loader off");
    check(dbg_connect_ack, 1'b0, "ack off");
    cmd(`LAC_OP_ADVANCE, 3'h1);
    check(st[2:0], 0, "no boot");
    boot_mode_pin <= 1'b1;
    dbg_connect_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmd(`LAC_OP_ADVANCE, 3'h1);
    expect_st(adv(0, 1), 0);
    k = xs();
    wr(`LAC_OFF_KEY, k);
    cmd(`LAC_OP_INJECT, `LAC_KSEL_SEC);
    check(st[8], 1'b1, "secure key");
    cmd(`LAC_OP_INJECT, `LAC_KSEL_NS);
    check(st[9], 1'b0, "ns key in sec dev");
    cmd(`LAC_OP_ADVANCE, 3'h2);
    expect_st(adv(1, 2), 0);
    cmd(`LAC_OP_ADVANCE, 3'h1);
    expect_st(2, 2);
    cmd(`LAC_OP_INJECT, `LAC_KSEL_SEC);
    expect_st(2, 2);
    // Wrong answer, then a fresh challenge answered right
    n0 = erase_cnt;
    wr(`LAC_OFF_CMD, {25'h0, 3'h1, `LAC_OP_REGRESS});
    rd(`LAC_OFF_CHAL, ch);
    wr(`LAC_OFF_RESP, answer(ch, k) ^ (xs() | 32'h1));
    settle();
    expect_st(2, 3);
    wr(`LAC_OFF_CMD, {25'h0, 3'h1, `LAC_OP_REGRESS});
    rd(`LAC_OFF_CHAL, c2);
    check(c2 != ch, 1'b1, "fresh challenge");
    wr(`LAC_OFF_RESP, answer(c2, k));
    settle();
    expect_st(1, 0);
    check(erase_cnt, n0, "flash kept");
    cmd(`LAC_OP_ADVANCE, 3'h3);
    expect_st(3, 0);
    // Keyless and direct regressions from deployed
    for (int t = 2; t > 0; t--)
    begin
      wr(`LAC_OFF_CMD, {25'h0, 3'(t), `LAC_OP_REGRESS});
      cmd(`LAC_OP_ABORT, 3'h0);
      check(st[2:0], 3, "no regression");
    end
    flash_perm_prot <= 1'b1;
    cmd(`LAC_OP_ERASE, 3'h0);
    expect_st(3, 2);
    flash_perm_prot <= 1'b0;
    erase_dly <= 8'(xs() & 32'hf);
    cmd(`LAC_OP_ERASE, 3'h0);
    expect_st(1, 0);
    check(erase_cnt, n0 + 1, "erased");
    // Return key: aborted exchange, then a good one
    cmd(`LAC_OP_INJECT, `LAC_KSEL_RET);
    wr(`LAC_OFF_CMD, {25'h0, 3'h6, `LAC_OP_REGRESS});
    cmd(`LAC_OP_ABORT, 3'h0);
    expect_st(1, 3);
    wr(`LAC_OFF_CMD, {25'h0, 3'h6, `LAC_OP_REGRESS});
    rd(`LAC_OFF_CHAL, ch);
    wr(`LAC_OFF_RESP, answer(ch, k));
    settle();
    expect_st(6, 0);
    cmd(`LAC_OP_ERASE_DIS, 3'h0);
    check(st[7], 1'b1, "erase disabled");
    reboot(1'b0, chip_manufacture_state);
    rd(`LAC_OFF_STAT, st);
    check(st[10:7], 4'hb, "reloaded");
    cmd(`LAC_OP_ERASE, 3'h0);
    expect_st(6, 2);
    check(erase_cnt, n0 + 1, "no erase");
    tally_and_finish();
  end
  // Cuts a hang short
  initial
  begin
    #300000;
    failures++;
    tally_and_finish();
  end
endmodule
bind lac_top lac_top_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .boot_mode_pin(boot_mode_pin),
  .dbg_connect_pin(dbg_connect_pin), .dbg_connect_ack(dbg_connect_ack),
  .dbg_secure_en(dbg_secure_en), .dbg_nonsecure_en(dbg_nonsecure_en), .loader_en(loader_en),
  .flash_access(flash_access), .flash_perm_prot(flash_perm_prot),
  .flash_erase_req(flash_erase_req), .flash_erase_done(flash_erase_done), .nv_lc(nv_lc),
  .nv_erase_dis(nv_erase_dis), .nv_wr(nv_wr), .nv_lc_next(nv_lc_next),
  .nv_erase_dis_next(nv_erase_dis_next));
`default_nettype wire
